// File: hw/alu_datapath_defines.vh
// Purpose: shared constants for the register and arithmetic datapath
// Assumes: 32-bit Avalon-MM register window, word aligned
// Notes: header holds definitions only
`ifndef ALU_DATAPATH_DEFINES_VH
`define ALU_DATAPATH_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_ACC_A 5'h00
`define OFS_ACC_B 5'h04
`define OFS_FENCE 5'h08
`define OFS_QUOT 5'h0C
`define OFS_PC 5'h10
`define OFS_STATUS 5'h14

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ST_HIT_A 0
`define ST_HIT_B 1
`define ST_GATE 2
`define ST_PICK 3
`define ST_SKIP 4
`define ST_VIOL 5

// ----------------------------------------------------------------
// reset values and function codes
// ----------------------------------------------------------------
`define WORD_RST 16'h0000
`define FN_PASS_R 4'h0
`define FN_ADD 4'h9
`define FN_SUB 4'h6
`define FN_IOR 4'hE
`define FN_XOR 4'h6
`define FN_NOR 4'h1
`define FN_AND 4'hB
`define RSEL_A 2'h0
`define RSEL_B 2'h1
`define RSEL_Q 2'h2
`define RSEL_F 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define RBUS_HOLD_NS 200
`define RBUS_HOLD_CYC (`RBUS_HOLD_NS / `CLK_PERIOD_NS)

`endif

// File: hw/cpu_register_alu_datapath.v
// Purpose: processor register file, program counter, R/S bus selection and function generator
// Assumes: decoder strobes are synchronous to i_clock; panel levels are asynchronous
// Notes: two-phase timing folded onto one 40 MHz clock; shifter is a straight pass
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "alu_datapath_defines.vh"

module cpu_register_alu_datapath (
	input wire i_clock,
	input wire i_resetn,
	input wire [4:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output wire [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	input wire i_special_acc_check,
	input wire i_store_acc_check,
	input wire i_source_code_a,
	input wire i_skip_acc_check,
	input wire i_protect_check_code,
	input wire i_protect_enable,
	input wire i_in_protected_area,
	input wire i_panel_temp,
	input wire i_panel_enable,
	input wire [15:0] i_temp_data,
	input wire [15:0] i_sbus_other,
	input wire i_store_acc_a,
	input wire i_store_acc_b,
	input wire i_acc_a_parallel_mode,
	input wire i_acc_a_serial_in,
	input wire i_store_fence_reg,
	input wire i_store_quotient_reg,
	input wire i_fence_load_mode,
	input wire i_quotient_load_mode,
	input wire i_fence_shift_left,
	input wire i_quotient_shift_left,
	input wire i_fence_serial_in,
	input wire i_quotient_serial_in,
	input wire i_pc_increment,
	input wire i_pc_carry_in,
	input wire i_pc_store,
	input wire [3:0] i_scratch_write,
	input wire [3:0] i_scratch_read,
	input wire i_rbus_mux_enable_n,
	input wire i_rbus_sel_hi,
	input wire i_rbus_sel_lo,
	input wire i_logic_mode,
	input wire i_carry_in_n,
	input wire i_func_sel3,
	input wire i_func_sel2,
	input wire i_func_sel1,
	input wire i_func_sel0,
	output wire [15:0] o_result,
	output wire [15:0] o_acc_a,
	output wire [15:0] o_acc_b,
	output wire [15:0] o_fence,
	output wire [15:0] o_quotient,
	output wire [15:0] o_pc,
	output wire o_acc_a_hit_n,
	output wire o_acc_b_hit_n,
	output wire o_micro_skip,
	output wire o_protect_violation,
	output wire o_select_temp_reg,
	output wire o_rbus_to_sbus,
	output wire o_rbus_stable
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function [15:0] pick_reg;
		input [1:0] sel;
		input [15:0] a;
		input [15:0] b;
		input [15:0] q;
		input [15:0] f;
		begin
			case (sel)
				`RSEL_A: pick_reg = a;
				`RSEL_B: pick_reg = b;
				`RSEL_Q: pick_reg = q;
				default: pick_reg = f;
			endcase
		end
	endfunction

	function [15:0] shift_word;
		input [15:0] w;
		input left;
		input fill;
		begin
			if (left) begin
				shift_word = {w[14:0], fill};
			end else begin
				shift_word = {fill, w[15:1]};
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [15:0] acc_a_ff;
	reg [15:0] acc_b_ff;
	reg [15:0] fence_ff;
	reg [15:0] quot_ff;
	reg [15:0] pc_ff;
	reg [15:0] scratch_ff [0:3];
	reg acc_a_hit_ff;
	reg acc_b_hit_ff;
	reg acc_a_hit_n_ff;
	reg acc_b_hit_n_ff;
	reg acc_display_gate_ff;
	reg acc_display_pick_ff;
	reg skip_ff;
	reg viol_ff;
	reg sel_temp_ff;
	reg rbus_to_sbus_ff;
	reg [15:0] result_ff;
	reg [1:0] panel_meta_ff;
	reg [1:0] panel_sync_ff;
	reg [2:0] rsel_ff;
	reg [3:0] hold_cnt_ff;
	reg stable_ff;
	reg wait_ff;
	reg [31:0] rdata_ff;

	// ----------------------------------------------------------------
	// R-bus and S-bus
	// ----------------------------------------------------------------
	wire either_acc_hit = acc_a_hit_ff | acc_b_hit_ff;
	wire halt_show = panel_sync_ff[0] & panel_sync_ff[1] & ~acc_display_gate_ff;
	reg [1:0] rsel;
	reg rbus_on;
	reg [15:0] rbus;
	reg [15:0] sbus;
	reg [15:0] scratch_out;
	integer k;

	always @* begin
		rsel = {i_rbus_sel_hi, i_rbus_sel_lo};
		rbus_on = ~i_rbus_mux_enable_n;
		if (halt_show) begin
			rsel = {1'b0, acc_display_pick_ff};
			rbus_on = 1'b1;
		end
		rbus = rbus_on ? pick_reg(rsel, acc_a_ff, acc_b_ff, quot_ff, fence_ff) : 16'h0000;
	end

	always @* begin
		scratch_out = 16'h0000;
		for (k = 0; k < 4; k = k + 1) begin
			if (i_scratch_read[k]) begin
				scratch_out = scratch_out | scratch_ff[k];
			end
		end
		sbus = scratch_out | i_sbus_other;
		if (i_source_code_a) begin
			sbus = sbus | (either_acc_hit ? rbus : i_temp_data);
		end
	end

	// ----------------------------------------------------------------
	// function generator
	// ----------------------------------------------------------------
	// operand term x and y cover all sixteen selects; logic is the complement of x^y
	wire [3:0] fsel = {i_func_sel3, i_func_sel2, i_func_sel1, i_func_sel0};
	wire [15:0] op_x = rbus | (fsel[0] ? sbus : 16'h0000) | (fsel[1] ? ~sbus : 16'h0000);
	wire [15:0] op_y = rbus & ((fsel[2] ? ~sbus : 16'h0000) | (fsel[3] ? sbus : 16'h0000));
	wire [16:0] arith = {1'b0, op_x} + {1'b0, op_y} + {16'h0000, ~i_carry_in_n};
	wire [15:0] result = i_logic_mode ? ~(op_x ^ op_y) : arith[15:0];

	// ----------------------------------------------------------------
	// accumulator address detection
	// ----------------------------------------------------------------
	wire low_page = (result[14:1] == 14'h0000);
	wire name_a = low_page & ~result[0];
	wire name_b = low_page & result[0];
	wire outside = ~i_in_protected_area;

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_a_hit_ff <= 1'b0;
			acc_b_hit_ff <= 1'b0;
			acc_a_hit_n_ff <= 1'b1;
			acc_b_hit_n_ff <= 1'b1;
			acc_display_gate_ff <= 1'b1;
			acc_display_pick_ff <= 1'b0;
			skip_ff <= 1'b0;
			viol_ff <= 1'b0;
		end else begin
			if (i_special_acc_check) begin
				acc_a_hit_ff <= name_a;
				acc_b_hit_ff <= name_b;
				// active-low copies kept as flops so the store strobes leave a register
				acc_a_hit_n_ff <= ~name_a;
				acc_b_hit_n_ff <= ~name_b;
			end
			acc_display_gate_ff <= ~either_acc_hit;
			acc_display_pick_ff <= acc_b_hit_ff;
			skip_ff <= (i_skip_acc_check & either_acc_hit) |
				(i_protect_check_code & ~either_acc_hit &
				((outside & result[15]) | (~i_protect_enable & i_in_protected_area)));
			viol_ff <= i_protect_check_code & ~either_acc_hit & i_protect_enable &
				i_in_protected_area;
		end
	end

	// ----------------------------------------------------------------
	// accumulators, F and Q
	// ----------------------------------------------------------------
	wire load_a = i_store_acc_a | (i_store_acc_check & acc_a_hit_ff);
	wire load_b = i_store_acc_b | (i_store_acc_check & acc_b_hit_ff);

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_a_ff <= `WORD_RST;
			acc_b_ff <= `WORD_RST;
			fence_ff <= `WORD_RST;
			quot_ff <= `WORD_RST;
		end else begin
			if (load_a) begin
				acc_a_ff <= i_acc_a_parallel_mode ? result :
					shift_word(acc_a_ff, 1'b0, i_acc_a_serial_in);
			end
			if (load_b) begin
				acc_b_ff <= result;
			end
			if (i_store_fence_reg) begin
				fence_ff <= i_fence_load_mode ? result :
					shift_word(fence_ff, i_fence_shift_left, i_fence_serial_in);
			end
			if (i_store_quotient_reg) begin
				quot_ff <= i_quotient_load_mode ? result :
					shift_word(quot_ff, i_quotient_shift_left, i_quotient_serial_in);
			end
		end
	end

	// ----------------------------------------------------------------
	// scratch pad
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_scratch
			always @(posedge i_clock or negedge i_resetn) begin
				if (!i_resetn) begin
					scratch_ff[g] <= `WORD_RST;
				end else if (i_scratch_write[g]) begin
					scratch_ff[g] <= result;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	wire bus_req = (i_avs_read | i_avs_write) & wait_ff;
	// a bus write lands on the edge that completes the transfer, with waitrequest low
	wire bus_pc_wr = i_avs_write & ~wait_ff & (i_avs_address == `OFS_PC);

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_ff <= `WORD_RST;
		end else if (bus_pc_wr) begin
			// manual load from the panel side of the bus
			pc_ff <= i_avs_writedata[15:0];
		end else if (i_pc_store) begin
			pc_ff <= result;
		end else if (i_pc_increment & i_pc_carry_in) begin
			pc_ff <= pc_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// panel sync, display selection, R-bus hold
	// ----------------------------------------------------------------
	// panel levels come from switches; only the second stage is read
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			panel_meta_ff <= 2'h0;
			panel_sync_ff <= 2'h0;
			sel_temp_ff <= 1'b0;
			rbus_to_sbus_ff <= 1'b0;
			result_ff <= `WORD_RST;
			rsel_ff <= 3'h0;
			hold_cnt_ff <= 4'h0;
			stable_ff <= 1'b0;
		end else begin
			panel_meta_ff <= {i_panel_enable, i_panel_temp};
			panel_sync_ff <= panel_meta_ff;
			sel_temp_ff <= panel_sync_ff[0] & panel_sync_ff[1] & ~halt_show;
			rbus_to_sbus_ff <= i_source_code_a & either_acc_hit;
			result_ff <= result;
			rsel_ff <= {rbus_on, rsel};
			// select change restarts the window in which the R-bus is held
			if (rsel_ff != {rbus_on, rsel}) begin
				hold_cnt_ff <= 4'h0;
				stable_ff <= 1'b0;
			end else if (hold_cnt_ff != `RBUS_HOLD_CYC) begin
				hold_cnt_ff <= hold_cnt_ff + 4'h1;
				stable_ff <= 1'b0;
			end else begin
				stable_ff <= rbus_on;
			end
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// one wait cycle: waitrequest drops for one cycle, then rises again
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else begin
			wait_ff <= ~bus_req;
			if (bus_req & i_avs_read) begin
				case (i_avs_address)
					`OFS_ACC_A: rdata_ff <= {16'h0000, acc_a_ff};
					`OFS_ACC_B: rdata_ff <= {16'h0000, acc_b_ff};
					`OFS_FENCE: rdata_ff <= {16'h0000, fence_ff};
					`OFS_QUOT: rdata_ff <= {16'h0000, quot_ff};
					`OFS_PC: rdata_ff <= {16'h0000, pc_ff};
					`OFS_STATUS: rdata_ff <= {26'h0000000, viol_ff, skip_ff,
						acc_display_pick_ff, acc_display_gate_ff, acc_b_hit_ff, acc_a_hit_ff};
					default: rdata_ff <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_result = result_ff;
	assign o_acc_a = acc_a_ff;
	assign o_acc_b = acc_b_ff;
	assign o_fence = fence_ff;
	assign o_quotient = quot_ff;
	assign o_pc = pc_ff;
	assign o_acc_a_hit_n = acc_a_hit_n_ff;
	assign o_acc_b_hit_n = acc_b_hit_n_ff;
	assign o_micro_skip = skip_ff;
	assign o_protect_violation = viol_ff;
	assign o_select_temp_reg = sel_temp_ff;
	assign o_rbus_to_sbus = rbus_to_sbus_ff;
	assign o_rbus_stable = stable_ff;

endmodule

// File: tb/datapath_checker_assertions.sv
// Purpose: concurrent checks on hit flags, skips and program counter
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only top-level ports; results are compared one cycle after the cause
`timescale 1ns/10ps
module datapath_checker (
	input wire i_clock,
	input wire i_resetn,
	input wire i_avs_write,
	input wire i_special_acc_check,
	input wire i_skip_acc_check,
	input wire i_protect_check_code,
	input wire i_protect_enable,
	input wire i_in_protected_area,
	input wire i_pc_increment,
	input wire i_pc_carry_in,
	input wire i_pc_store,
	input wire [15:0] o_result,
	input wire [15:0] o_pc,
	input wire o_acc_a_hit_n,
	input wire o_acc_b_hit_n,
	input wire o_micro_skip,
	input wire o_protect_violation
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	wire any_hit = !(o_acc_a_hit_n && o_acc_b_hit_n);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	hit_exclusive_a: assert property (o_acc_a_hit_n || o_acc_b_hit_n)
		else $error("both accumulator hits set");
	// the registered result is the word the hit logic saw one edge earlier
	hit_select_a: assert property ($past(i_special_acc_check) && o_result[14:1] == 14'h0000 |->
		o_acc_a_hit_n == o_result[0] && o_acc_b_hit_n == !o_result[0])
		else $error("accumulator hit does not follow address");
	hit_clear_a: assert property ($past(i_special_acc_check) && o_result[14:1] != 14'h0000 |->
		o_acc_a_hit_n && o_acc_b_hit_n)
		else $error("hit kept on plain address");
	skip_hit_a: assert property (i_skip_acc_check && !i_special_acc_check && any_hit |=>
		o_micro_skip)
		else $error("no skip on accumulator hit");
	no_viol_a: assert property (i_protect_check_code && !i_special_acc_check && any_hit |=>
		!o_protect_violation)
		else $error("violation on accumulator address");
	prot_skip_a: assert property (i_protect_check_code && !i_special_acc_check && !any_hit &&
		i_in_protected_area && !i_protect_enable |=> o_micro_skip)
		else $error("no skip with protect off");
	pc_step_a: assert property (i_pc_increment && i_pc_carry_in && !i_pc_store && !i_avs_write
		|=> o_pc == $past(o_pc) + 16'h0001)
		else $error("counter did not step by one");
	pc_load_a: assert property (i_pc_store && !i_avs_write |=> o_pc == o_result)
		else $error("counter did not load result");
endmodule

bind cpu_register_alu_datapath datapath_checker chk_u (.*);

// File: tb/panel_model.sv
// Purpose: operator panel and memory data register seen by the datapath
// Assumes: halt request from the bench, one clock
// Notes: enable follows temp by a cycle, as a real panel need not raise both together
`timescale 1ns/10ps
module panel_model #(
	parameter logic [15:0] TEMP_WORD = 16'h5A5A
) (
	input wire i_clock,
	input wire i_halt,
	output logic o_panel_temp,
	output logic o_panel_enable,
	output logic [15:0] o_temp_data
);
	initial o_panel_temp = 1'h0;
	initial o_panel_enable = 1'h0;
	assign o_temp_data = TEMP_WORD;
	always @(posedge i_clock) begin
		o_panel_temp <= i_halt;
		o_panel_enable <= o_panel_temp & i_halt;
	end
endmodule

// File: tb/tb_cpu_register_alu_datapath.sv
// Purpose: directed scenarios for the register and arithmetic datapath
// Assumes: 40 MHz clock, Avalon-MM register window
// Notes: each scenario task starts with a clock edge and drives right after it
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module tb_cpu_register_alu_datapath;
	logic i_clock = 1'h0, i_resetn = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
	logic [4:0] i_avs_address = 5'h00;
	logic [31:0] i_avs_writedata = 32'h0, rd;
	logic i_special_acc_check = 1'h0, i_store_acc_check = 1'h0, i_source_code_a = 1'h0;
	logic i_skip_acc_check = 1'h0, i_protect_check_code = 1'h0, i_protect_enable = 1'h0;
	logic i_in_protected_area = 1'h0, i_store_acc_a = 1'h0, i_store_acc_b = 1'h0;
	logic i_acc_a_parallel_mode = 1'h1, i_acc_a_serial_in = 1'h1, i_store_fence_reg = 1'h0;
	logic i_store_quotient_reg = 1'h0, i_fence_load_mode = 1'h1, i_quotient_load_mode = 1'h1;
	logic i_fence_shift_left = 1'h1, i_quotient_shift_left = 1'h0, i_fence_serial_in = 1'h0;
	logic i_quotient_serial_in = 1'h1, i_pc_increment = 1'h0, i_pc_carry_in = 1'h0;
	logic i_pc_store = 1'h0, i_rbus_mux_enable_n = 1'h1, i_rbus_sel_hi = 1'h0;
	logic i_rbus_sel_lo = 1'h0, i_logic_mode = 1'h0, i_carry_in_n = 1'h1, halt = 1'h0;
	logic i_func_sel3 = 1'h0, i_func_sel2 = 1'h0, i_func_sel1 = 1'h0, i_func_sel0 = 1'h0;
	logic [3:0] i_scratch_write = 4'h0, i_scratch_read = 4'h0;
	logic [15:0] i_sbus_other = 16'h0000;
	wire [15:0] i_temp_data, o_result, o_acc_a, o_acc_b, o_fence, o_quotient, o_pc;
	wire [31:0] o_avs_readdata;
	wire i_panel_temp, i_panel_enable, o_avs_waitrequest, o_acc_a_hit_n, o_acc_b_hit_n;
	wire o_micro_skip, o_protect_violation, o_select_temp_reg, o_rbus_to_sbus, o_rbus_stable;
	int error_cnt = 0, total_checks = 0;

	always #12.5 i_clock = ~i_clock;
	cpu_register_alu_datapath dut_u (.*);
	panel_model panel_u (.i_clock(i_clock), .i_halt(halt), .o_panel_temp(i_panel_temp),
		.o_panel_enable(i_panel_enable), .o_temp_data(i_temp_data));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task results;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task tick;
		@(posedge i_clock);
	endtask
	// c is {mode, select[3:0], carry_in_n}
	task fn(input logic [5:0] c, input logic [15:0] s);
		{i_logic_mode, i_func_sel3, i_func_sel2, i_func_sel1, i_func_sel0, i_carry_in_n} <= c;
		i_sbus_other <= s;
	endtask
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		tick;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_read <= !wr;
		i_avs_write <= wr;
		// values read right after an edge are those the slave showed at that edge
		tick;
		while (o_avs_waitrequest !== 1'h0 && n < 50) begin
			tick;
			n++;
		end
		rd = o_avs_readdata;
		i_avs_read <= 1'h0;
		i_avs_write <= 1'h0;
		if (n == 50) begin
			error_cnt++;
			results;
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic [15:0] v[4];
		logic [5:0] op[9];
		logic [15:0] e[9];
		v = '{16'h00F0, 16'h0B0B, 16'h0C0C, 16'h0F0F};
		op = '{6'h01, 6'h3D, 6'h2D, 6'h23, 6'h37, 6'h13, 6'h0C, 6'h0D, 6'h12};
		e = '{16'h00F0, 16'h0FF3, 16'h0FC3, 16'hF00C, 16'h0030, 16'h1023, 16'hF1BD, 16'hF1BC,
			16'h1024};
		for (int k = 0; k < 4; k++) begin
			tick;
			fn(6'h13, v[k]);
			{i_store_fence_reg, i_store_quotient_reg, i_store_acc_b, i_store_acc_a} <= 4'(1 << k);
		end
		tick;
		{i_store_fence_reg, i_store_quotient_reg, i_store_acc_b, i_store_acc_a} <= 4'h0;
		@(negedge i_clock);
		`CHK({o_fence, o_quotient, o_acc_b, o_acc_a}, {v[3], v[2], v[1], v[0]})
		for (int k = 0; k < 13; k++) begin
			tick;
			{i_rbus_sel_hi, i_rbus_sel_lo} <= (k < 4) ? 2'(k) : 2'h0;
			i_rbus_mux_enable_n <= 1'h0;
			fn((k < 4) ? 6'h01 : op[k - 4], (k < 4) ? 16'h0000 : 16'h0F33);
			tick;
			@(negedge i_clock);
			`CHK(o_result, (k < 4) ? v[k] : e[k - 4])
		end
		`CHK(o_rbus_stable, 1'h1)
		tick;
		i_rbus_mux_enable_n <= 1'h1;
		{i_acc_a_parallel_mode, i_fence_load_mode, i_quotient_load_mode} <= 3'h0;
		{i_store_acc_a, i_store_fence_reg, i_store_quotient_reg} <= 3'h7;
		tick;
		{i_acc_a_parallel_mode, i_fence_load_mode, i_quotient_load_mode} <= 3'h7;
		{i_store_acc_a, i_store_fence_reg, i_store_quotient_reg} <= 3'h0;
		@(negedge i_clock);
		`CHK({o_acc_a, o_fence, o_quotient}, {16'h8078, 16'h1E1E, 16'h8606})
		`CHK(o_rbus_stable, 1'h0)
	endtask

	task t_hits;
		for (int k = 0; k < 2; k++) begin
			tick;
			fn(6'h13, 16'(k));
			i_special_acc_check <= 1'h1;
			tick;
			i_special_acc_check <= 1'h0;
			fn(6'h13, 16'h1230 + 16'(k));
			{i_store_acc_check, i_skip_acc_check, i_source_code_a} <= 3'h7;
			tick;
			{i_store_acc_check, i_skip_acc_check, i_source_code_a} <= 3'h0;
			@(negedge i_clock);
			`CHK({o_acc_b_hit_n, o_acc_a_hit_n}, (k == 1) ? 2'h1 : 2'h2)
			`CHK((k == 1) ? o_acc_b : o_acc_a, 16'h1230 + 16'(k))
			`CHK({o_micro_skip, o_rbus_to_sbus}, 2'h3)
		end
		bus(1'h0, 5'h14, 32'h0);
		`CHK(rd, 32'h0000000A)
		tick;
		halt <= 1'h1;
		fn(6'h01, 16'h0000);
		repeat (6) tick;
		@(negedge i_clock);
		`CHK({o_select_temp_reg, o_result}, {1'h0, 16'h1231})
		tick;
		halt <= 1'h0;
		{i_protect_check_code, i_protect_enable, i_in_protected_area} <= 3'h7;
		tick;
		i_protect_check_code <= 1'h0;
		fn(6'h13, 16'h0002);
		i_special_acc_check <= 1'h1;
		@(negedge i_clock);
		`CHK(o_protect_violation, 1'h0)
		tick;
		i_special_acc_check <= 1'h0;
		i_protect_check_code <= 1'h1;
		tick;
		i_protect_enable <= 1'h0;
		@(negedge i_clock);
		`CHK({o_protect_violation, o_acc_a_hit_n, o_acc_b_hit_n}, 3'h7)
		tick;
		i_protect_check_code <= 1'h0;
		i_source_code_a <= 1'h1;
		fn(6'h13, 16'h0000);
		@(negedge i_clock);
		`CHK(o_micro_skip, 1'h1)
		tick;
		i_source_code_a <= 1'h0;
		@(negedge i_clock);
		`CHK({o_rbus_to_sbus, o_result}, {1'h0, 16'h5A5A})
		tick;
		i_in_protected_area <= 1'h0;
		i_protect_check_code <= 1'h1;
		fn(6'h13, 16'h8000);
		tick;
		i_protect_check_code <= 1'h0;
		@(negedge i_clock);
		`CHK(o_micro_skip, 1'h1)
		tick;
		halt <= 1'h1;
		repeat (6) tick;
		@(negedge i_clock);
		`CHK(o_select_temp_reg, 1'h1)
		tick;
		halt <= 1'h0;
	endtask

	task t_pc;
		bus(1'h1, 5'h10, 32'h00007FFE);
		{i_pc_increment, i_pc_carry_in} <= 2'h3;
		tick;
		i_pc_carry_in <= 1'h0;
		tick;
		i_pc_increment <= 1'h0;
		bus(1'h0, 5'h10, 32'h0);
		`CHK(rd, 32'h00007FFF)
		bus(1'h0, 5'h18, 32'h0);
		`CHK(rd, 32'h00000000)
		fn(6'h13, 16'h0ABC);
		i_scratch_write <= 4'h1;
		tick;
		i_scratch_write <= 4'h0;
		fn(6'h13, 16'h0000);
		i_scratch_read <= 4'h1;
		i_pc_store <= 1'h1;
		tick;
		i_scratch_read <= 4'h0;
		i_pc_store <= 1'h0;
		@(negedge i_clock);
		`CHK(o_pc, 16'h0ABC)
	endtask

	initial begin
		repeat (12) tick;
		i_resetn <= 1'h1;
		@(negedge i_clock);
		`CHK({o_avs_waitrequest, o_acc_a_hit_n, o_acc_b_hit_n, o_pc}, {3'h7, 16'h0000})
		bus(1'h0, 5'h14, 32'h0);
		`CHK(rd, 32'h00000004)
		t_regs;
		t_hits;
		t_pc;
		results;
	end
endmodule
